/* rx_port_map_pkg.sv */
// Package for the per-port remote identity and address remap register set.
// Assumes an 8-bit internal register access path behind the local I2C target.
package rx_port_map_pkg;
    localparam logic [7:0] PORT_SELECT_OFFSET   = 8'h4C;
    localparam logic [7:0] DATAPATH_ONE_OFFSET  = 8'h59;
    localparam logic [7:0] DATAPATH_TWO_OFFSET  = 8'h5A;
    localparam logic [7:0] SER_IDENT_OFFSET     = 8'h5B;
    localparam logic [7:0] SER_ALIAS_OFFSET     = 8'h5C;
    localparam logic [7:0] TARGET_ZERO_OFFSET   = 8'h5D;
    localparam logic [7:0] TARGET_ONE_OFFSET    = 8'h5E;
    // Field positions
    localparam int KEEP_LOCAL_BIT    = 7;
    localparam int GPIO_COUNT_LSB    = 0;
    localparam int ADDR_FIELD_LSB    = 1;
    localparam int LOW_FLAG_BIT      = 0;
    localparam int PASS_THROUGH_BIT  = 6;
    localparam int ACK_ALL_BIT       = 5;
    localparam int NUM_PORTS         = 4;
    localparam int NUM_TARGETS       = 2;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [6:0] ADDR_DISABLED = 7'h00;
    // Forward GPIO count encodings
    typedef enum logic [1:0] {
        GPIO_NONE = 2'b00,
        GPIO_ONE  = 2'b01,
        GPIO_TWO  = 2'b10,
        GPIO_FOUR = 2'b11
    } gpio_count_t;
endpackage : rx_port_map_pkg

/* rx_port_map_decode.sv */
// Address decoder: alias match and remap of a local I2C target address.
// Assumes registers of the selected port feed it; purely combinational.
`timescale 1ns/10ps
module rx_port_map_decode (
    input  wire logic [6:0] target_addr,
    input  wire logic [6:0] ser_alias,
    input  wire logic [6:0] target_alias_zero,
    input  wire logic [6:0] target_alias_one,
    input  wire logic [6:0] phys_zero,
    input  wire logic [6:0] phys_one,
    input  wire logic       pass_enable,
    output logic            match_serializer,
    output logic            match_target,
    output logic [6:0]      remap_addr,
    output logic            forward_ok
);
    // Zero alias never matches, so it disables that path
    function automatic logic alias_hit(input logic [6:0] a, input logic [6:0] al);
        alias_hit = (al != rx_port_map_pkg::ADDR_DISABLED) && (a == al);
    endfunction : alias_hit

    always_comb begin
        match_serializer = alias_hit(target_addr, ser_alias);
        match_target     = 1'b0;
        remap_addr       = target_addr;
        if (alias_hit(target_addr, target_alias_zero)) begin
            match_target = 1'b1;
            remap_addr   = phys_zero;
        end else if (alias_hit(target_addr, target_alias_one)) begin
            match_target = 1'b1;
            remap_addr   = phys_one;
        end
        forward_ok = pass_enable && (match_serializer || match_target);
    end
endmodule : rx_port_map_decode

/* rx_port_remote_id_map.sv */
// Per receive port register bank: datapath override, forward GPIO count,
// remote serializer identity/alias, remote target address remap.
// Assumes a local I2C target front end gives single-cycle 8-bit reads/writes.
//
// Contract
// - Each register exists per port; port-select register picks the accessed copy.
// - Override bit set blocks forward-channel datapath loads; local values kept.
// - GPIO count code 00 none, 01 one, 10 two, 11 four.
// - Seven-bit serializer identifier auto-loads from the forward channel.
// - Freeze bit stops identifier auto-load; last written value kept.
// - Local target addresses compared with serializer alias; match goes remote.
// - Alias of zero disables access; nothing forwarded on it.
// - Self-acknowledge bit acks local writes to serializer regardless of remote.
// - Target slots hold address in bits 7:1; bit 0 reads zero.
// - Alias-addressed transaction gets slot physical address before forwarding.
// - Forward only when decode matches and pass-through enable is set.
// - Acknowledge-all bit acks every forwarded write regardless of lock.
`timescale 1ns/10ps
module rx_port_remote_id_map #(
    parameter int PORTS = rx_port_map_pkg::NUM_PORTS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // Local register access
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    // Forward channel loads, one strobe per port
    input  wire logic [PORTS-1:0] fc_load_datapath,
    input  wire logic [PORTS-1:0] fc_load_ident,
    input  wire logic [1:0]  fc_gpio_count,
    input  wire logic [6:0]  fc_ident,
    // Port-wide control bits of the selected port
    input  wire logic [7:0]  port_control,
    input  wire logic [6:0]  target_alias_zero,
    input  wire logic [6:0]  target_alias_one,
    // Local I2C transaction request
    input  wire logic [1:0]  xact_port,
    input  wire logic [6:0]  xact_addr,
    input  wire logic        xact_write,
    input  wire logic        link_locked,
    input  wire logic        remote_ack,
    output logic             xact_forward,
    output logic      [6:0]  xact_remap_addr,
    output logic             xact_ack,
    output logic [PORTS*3-1:0] gpio_active_count
);
    logic [1:0] port_sel_q;
    logic [PORTS-1:0] keep_local_q;
    logic [1:0] gpio_count_q [PORTS];
    logic [6:0] ident_q      [PORTS];
    logic [PORTS-1:0] hold_ident_q;
    logic [6:0] alias_q      [PORTS];
    logic [PORTS-1:0] self_ack_q;
    logic [6:0] phys_q       [PORTS][rx_port_map_pkg::NUM_TARGETS];
    logic       match_ser;
    logic [6:0] remap;
    logic       fwd_ok;

    // Decode of count code into active GPIO number
    function automatic logic [2:0] gpio_num(input logic [1:0] code);
        case (code)
            rx_port_map_pkg::GPIO_NONE: gpio_num = 3'h0;
            rx_port_map_pkg::GPIO_ONE:  gpio_num = 3'h1;
            rx_port_map_pkg::GPIO_TWO:  gpio_num = 3'h2;
            default:                    gpio_num = 3'h4;
        endcase
    endfunction : gpio_num

    // Port select; writes to the selector apply to every later access
    always_ff @(posedge clk) begin
        if (rst) begin
            port_sel_q <= 2'h0;
        end else if (reg_wr && reg_addr == rx_port_map_pkg::PORT_SELECT_OFFSET) begin
            port_sel_q <= reg_wdata[1:0];
        end
    end

    // Per-port register copies
    always_ff @(posedge clk) begin
        if (rst) begin
            keep_local_q <= '0;
            hold_ident_q <= '0;
            self_ack_q   <= '0;
            for (int p = 0; p < PORTS; p++) begin
                gpio_count_q[p] <= 2'h0;
                ident_q[p]      <= 7'h00;
                alias_q[p]      <= 7'h00;
                for (int t = 0; t < rx_port_map_pkg::NUM_TARGETS; t++) begin
                    phys_q[p][t] <= 7'h00;
                end
            end
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                // Remote loads first; a local write in the same cycle wins later
                if (fc_load_datapath[p] && !keep_local_q[p]) begin
                    gpio_count_q[p] <= fc_gpio_count;
                end
                if (fc_load_ident[p] && !hold_ident_q[p]) begin
                    ident_q[p] <= fc_ident;
                end
                if (reg_wr && port_sel_q == p[1:0]) begin
                    if (reg_addr == rx_port_map_pkg::DATAPATH_ONE_OFFSET) begin
                        keep_local_q[p] <= reg_wdata[rx_port_map_pkg::KEEP_LOCAL_BIT];
                        if (keep_local_q[p]) begin
                            gpio_count_q[p] <=
                                reg_wdata[rx_port_map_pkg::GPIO_COUNT_LSB +: 2];
                        end
                    end else if (reg_addr == rx_port_map_pkg::SER_IDENT_OFFSET) begin
                        ident_q[p]      <= reg_wdata[rx_port_map_pkg::ADDR_FIELD_LSB +: 7];
                        hold_ident_q[p] <= reg_wdata[rx_port_map_pkg::LOW_FLAG_BIT];
                    end else if (reg_addr == rx_port_map_pkg::SER_ALIAS_OFFSET) begin
                        alias_q[p]    <= reg_wdata[rx_port_map_pkg::ADDR_FIELD_LSB +: 7];
                        self_ack_q[p] <= reg_wdata[rx_port_map_pkg::LOW_FLAG_BIT];
                    end else if (reg_addr == rx_port_map_pkg::TARGET_ZERO_OFFSET) begin
                        phys_q[p][0] <= reg_wdata[rx_port_map_pkg::ADDR_FIELD_LSB +: 7];
                    end else if (reg_addr == rx_port_map_pkg::TARGET_ONE_OFFSET) begin
                        phys_q[p][1] <= reg_wdata[rx_port_map_pkg::ADDR_FIELD_LSB +: 7];
                    end
                    // Second datapath register is reserved: write dropped
                end
            end
        end
    end

    // Read data registered; reserved bits are zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= rx_port_map_pkg::RESET_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == rx_port_map_pkg::PORT_SELECT_OFFSET) begin
                reg_rdata <= {6'h00, port_sel_q};
            end else if (reg_addr == rx_port_map_pkg::DATAPATH_ONE_OFFSET) begin
                reg_rdata <= {keep_local_q[port_sel_q], 5'h00,
                              gpio_count_q[port_sel_q]};
            end else if (reg_addr == rx_port_map_pkg::SER_IDENT_OFFSET) begin
                reg_rdata <= {ident_q[port_sel_q], hold_ident_q[port_sel_q]};
            end else if (reg_addr == rx_port_map_pkg::SER_ALIAS_OFFSET) begin
                reg_rdata <= {alias_q[port_sel_q], self_ack_q[port_sel_q]};
            end else if (reg_addr == rx_port_map_pkg::TARGET_ZERO_OFFSET) begin
                reg_rdata <= {phys_q[port_sel_q][0], 1'b0};
            end else if (reg_addr == rx_port_map_pkg::TARGET_ONE_OFFSET) begin
                reg_rdata <= {phys_q[port_sel_q][1], 1'b0};
            end else begin
                reg_rdata <= rx_port_map_pkg::RESET_BYTE;
            end
        end
    end

    // Address hit flag for the local front end
    always_comb begin
        reg_hit = (reg_addr == rx_port_map_pkg::PORT_SELECT_OFFSET)
               || (reg_addr >= rx_port_map_pkg::DATAPATH_ONE_OFFSET
                   && reg_addr <= rx_port_map_pkg::TARGET_ONE_OFFSET);
    end

    rx_port_map_decode u_decode (
        .target_addr       (xact_addr),
        .ser_alias         (alias_q[xact_port]),
        .target_alias_zero (target_alias_zero),
        .target_alias_one  (target_alias_one),
        .phys_zero         (phys_q[xact_port][0]),
        .phys_one          (phys_q[xact_port][1]),
        .pass_enable       (port_control[rx_port_map_pkg::PASS_THROUGH_BIT]),
        .match_serializer  (match_ser),
        .match_target      (),
        .remap_addr        (remap),
        .forward_ok        (fwd_ok)
    );

    // Transaction outputs registered; ack is forced by either acknowledge bit
    always_ff @(posedge clk) begin
        if (rst) begin
            xact_forward    <= 1'b0;
            xact_remap_addr <= 7'h00;
            xact_ack        <= 1'b0;
        end else begin
            xact_forward    <= fwd_ok;
            xact_remap_addr <= remap;
            xact_ack        <= (fwd_ok && link_locked && remote_ack)
                || (xact_write && match_ser && self_ack_q[xact_port])
                || (xact_write && fwd_ok
                    && port_control[rx_port_map_pkg::ACK_ALL_BIT]);
        end
    end

    // Active GPIO count per port
    always_ff @(posedge clk) begin
        if (rst) begin
            gpio_active_count <= '0;
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                gpio_active_count[p*3 +: 3] <= gpio_num(gpio_count_q[p]);
            end
        end
    end
endmodule : rx_port_remote_id_map

/* rx_port_remote_id_map_sva.sv */
// Checker for the per-port remap register bank, watching only its top ports.
// Assumes registered outputs one edge after their inputs.
`timescale 1ns/10ps
module rx_port_remote_id_map_chk #(
    parameter int PORTS = 4
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_rdata,
    input wire logic             reg_hit,
    input wire logic [7:0]       port_control,
    input wire logic [6:0]       xact_addr,
    input wire logic             xact_write,
    input wire logic             link_locked,
    input wire logic             remote_ack,
    input wire logic             xact_forward,
    input wire logic             xact_ack,
    input wire logic [PORTS*3-1:0] gpio_active_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Decode, read-back and hold of the register path
    chk_hit_decode: assert property (reg_hit == (reg_addr == 8'h4C ||
        (reg_addr >= 8'h59 && reg_addr <= 8'h5E)))
        else $error("hit flag wrong");
    chk_unmapped_zero: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_reserved_zero: assert property (reg_rd && reg_addr == 8'h5A
        |=> reg_rdata == 8'h00)
        else $error("reserved register read not zero");
    chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    // Forwarding and acknowledge, tied to the inputs one edge earlier; then the legal port 0 GPIO count code
    chk_forward_pass: assert property (xact_forward |-> $past(port_control[6]))
        else $error("forward without pass-through");
    chk_alias_zero: assert property (xact_forward |-> $past(xact_addr) != 7'h00)
        else $error("forward on zero alias");
    chk_ack_all: assert property ($past(port_control[5] && xact_write)
        && xact_forward |-> xact_ack)
        else $error("ack-all write not acked");
    chk_ack_local: assert property (xact_ack && !$past(link_locked && remote_ack)
        |-> $past(xact_write))
        else $error("local ack on a read");
    chk_gpio_code: assert property (gpio_active_count[2:0]
        inside {3'h0, 3'h1, 3'h2, 3'h4})
        else $error("gpio count not a legal value");
endmodule : rx_port_remote_id_map_chk

bind rx_port_remote_id_map rx_port_remote_id_map_chk #(.PORTS(PORTS))
    i_rx_port_remote_id_map_chk (
    .clk, .rst, .reg_rd, .reg_addr, .reg_rdata, .reg_hit, .port_control, .xact_addr,
    .xact_write, .link_locked, .remote_ack, .xact_forward, .xact_ack, .gpio_active_count);

/* remote_serializer_model.sv */
// Remote serializer model: forward-channel load pulses and link status.
// Assumes nothing of the caller's timing: each task drives only on a rising edge.
`timescale 1ns/10ps
module remote_serializer_model #(
    parameter int PORTS = 4
) (
    input  wire logic        clk,
    output logic [PORTS-1:0] fc_load_datapath,
    output logic [PORTS-1:0] fc_load_ident,
    output logic [1:0]       fc_gpio_count,
    output logic [6:0]       fc_ident,
    output logic             link_locked,
    output logic             remote_ack
);
    // Idle: unlocked, no strobes
    initial begin
        fc_load_datapath = '0;
        fc_load_ident = '0;
        fc_gpio_count = 2'h0;
        fc_ident = 7'h00;
        link_locked = 1'b0;
        remote_ack = 1'b0;
    end
    // Data lines flip after the strobe so a stale sample never looks valid
    task automatic send_gpio(input int p, input logic [1:0] c);
        @(posedge clk);
        fc_gpio_count <= c;
        fc_load_datapath[p] <= 1'b1;
        @(posedge clk);
        fc_load_datapath <= '0;
        fc_gpio_count <= ~c;
        @(posedge clk);
    endtask : send_gpio
    task automatic send_ident(input int p, input logic [6:0] v);
        @(posedge clk);
        fc_ident <= v;
        fc_load_ident[p] <= 1'b1;
        @(posedge clk);
        fc_load_ident <= '0;
        fc_ident <= ~v;
        @(posedge clk);
    endtask : send_ident
    task automatic set_link(input logic l, input logic a);
        @(posedge clk);
        link_locked <= l;
        remote_ack <= a;
    endtask : set_link
endmodule : remote_serializer_model

/* rx_port_remote_id_map_tb.sv */
// Self-checking bench for the per-port remote identity and remap bank.
// Assumes single-cycle strobes and outputs one edge after their inputs.
`timescale 1ns/10ps
module rx_port_remote_id_map_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  port_control = 8'h00;
    logic [6:0]  target_alias_zero = 7'h00;
    logic [6:0]  target_alias_one = 7'h00;
    logic [1:0]  xact_port = 2'h0;
    logic [6:0]  xact_addr = 7'h00;
    logic        xact_write = 1'b0;
    logic [7:0]  reg_rdata;
    logic        reg_hit, xact_forward, xact_ack, link_locked, remote_ack;
    logic [6:0]  xact_remap_addr, fc_ident;
    logic [11:0] gpio_active_count;
    logic [3:0]  fc_load_datapath, fc_load_ident;
    logic [1:0]  fc_gpio_count;
    int          mismatches = 0;
    int          checked = 0;

    rx_port_remote_id_map #(.PORTS(4)) i_rx_port_remote_id_map (.clk, .rst, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .fc_load_datapath, .fc_load_ident,
        .fc_gpio_count, .fc_ident, .port_control, .target_alias_zero, .target_alias_one,
        .xact_port, .xact_addr, .xact_write, .link_locked, .remote_ack, .xact_forward,
        .xact_remap_addr, .xact_ack, .gpio_active_count);
    remote_serializer_model #(.PORTS(4)) i_partner (.clk, .fc_load_datapath, .fc_load_ident,
        .fc_gpio_count, .fc_ident, .link_locked, .remote_ack);

    // Free-running clock, 20 ns period
    initial forever #10 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // One-cycle strobes; the edge that drops them is the one that takes them
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd_reg
    task automatic xq(input logic [6:0] a, input logic w, input logic f, input logic k);
        @(posedge clk);
        {xact_addr, xact_write} <= {a, w};
        @(posedge clk);
        #1 check({6'h00, xact_forward, xact_ack}, {6'h00, f, k});
        // Return on an edge so that the caller's next drive lands on one
        @(posedge clk);
    endtask : xq

    // Hang guard: far beyond the length of the main sequence
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int a = 'h59; a <= 'h5E; a++) rd_reg(8'(a), 8'h00);
        // Port copies stay apart
        wr_reg(8'h5C, 8'h20);
        wr_reg(8'h4C, 8'h01);
        rd_reg(8'h5C, 8'h00);
        wr_reg(8'h5C, 8'h40);
        wr_reg(8'h4C, 8'h00);
        rd_reg(8'h5C, 8'h20);
        wr_reg(8'h5A, 8'hFF);
        rd_reg(8'h5A, 8'h00);
        rd_reg(8'h70, 8'h00);
        // Count field refuses a write until the override is already set
        wr_reg(8'h59, 8'hFF);
        rd_reg(8'h59, 8'h80);
        i_partner.send_gpio(0, 2'h1);
        rd_reg(8'h59, 8'h80);
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h59, 8'h80 | 8'(c));
            repeat (2) @(posedge clk);
            #1 check({5'h00, gpio_active_count[2:0]}, 8'(c == 3 ? 4 : c));
        end
        check({5'h00, gpio_active_count[5:3]}, 8'h00);
        wr_reg(8'h59, 8'h00);
        i_partner.send_gpio(0, 2'h2);
        rd_reg(8'h59, 8'h02);
        i_partner.send_ident(0, 7'h2A);
        rd_reg(8'h5B, 8'h54);
        wr_reg(8'h5B, 8'h23);
        i_partner.send_ident(0, 7'h2A);
        rd_reg(8'h5B, 8'h23);
        wr_reg(8'h5D, 8'hFF);
        rd_reg(8'h5D, 8'hFE);
        // Transactions: alias 0x30, slot zero alias 0x60 to physical 0x50
        wr_reg(8'h5D, 8'hA0);
        wr_reg(8'h5C, 8'h60);
        target_alias_zero <= 7'h60;
        port_control <= 8'h40;
        xq(7'h30, 1'b0, 1'b1, 1'b0);
        xq(7'h60, 1'b1, 1'b1, 1'b0);
        check({1'b0, xact_remap_addr}, 8'h50);
        i_partner.set_link(1'b1, 1'b1);
        xq(7'h60, 1'b0, 1'b1, 1'b1);
        i_partner.set_link(1'b0, 1'b0);
        port_control <= 8'h60;
        xq(7'h60, 1'b1, 1'b1, 1'b1);
        port_control <= 8'h40;
        wr_reg(8'h5C, 8'h61);
        xq(7'h30, 1'b1, 1'b1, 1'b1);
        port_control <= 8'h00;
        xq(7'h60, 1'b1, 1'b0, 1'b0);
        port_control <= 8'h40;
        target_alias_zero <= 7'h00;
        wr_reg(8'h5C, 8'h00);
        xq(7'h00, 1'b0, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule : rx_port_remote_id_map_tb
